/* File: fnp_pkg.sv */
package fnp_pkg;
   // Switch field layout
   localparam int ADDR_LSB = 0;
   localparam int ADDR_W = 6;
   localparam int RATE_SW_A = 6;
   localparam int RATE_SW_B = 7;
   // Bit-rate codes
   typedef enum logic [1:0] {
      FNP_RATE_125K = 2'h0,
      FNP_RATE_250K = 2'h1,
      FNP_RATE_500K = 2'h2,
      FNP_RATE_BAD = 2'h3
   } fnp_rate_e;
   // Object addressing
   localparam logic [7:0] IMG_CLASS = 8'h04;
   localparam logic [7:0] IN_INSTANCE = 8'h01;
   localparam logic [7:0] OUT_INSTANCE = 8'h15;
   localparam logic [7:0] IMG_ATTR = 8'h03;
   // Image fields
   localparam int SENSOR_LSB = 0;
   localparam int STATE_LSB = 4;
   // Valve-type selection
   typedef enum logic [1:0] {
      FNP_VT_RAW = 2'h0,
      FNP_VT_SINGLE = 2'h1,
      FNP_VT_DOUBLE = 2'h2,
      FNP_VT_SEAT = 2'h3
   } fnp_vtype_e;
   localparam logic [7:0] OUT_RESET = 8'h00;
   localparam logic [2:0] SAFE_RESET = 3'h0;
   // Master access kinds
   typedef enum logic [1:0] {
      FNP_ACC_NONE = 2'h0,
      FNP_ACC_READ = 2'h1,
      FNP_ACC_WRITE = 2'h3
   } fnp_acc_e;
endpackage : fnp_pkg

/* File: fnp_link_if.sv */
`timescale 1ns/1ns
`default_nettype none
interface fnp_link_if;
   logic restart;
   logic cyclic;
   logic [1:0] access;
   logic [7:0] class_id;
   logic [7:0] instance_id;
   logic [7:0] attr_id;
   logic [7:0] wdata;
   logic [7:0] rdata;
   logic ack;
   logic err;
   logic online;
   modport node (input restart, cyclic, access, class_id, instance_id,
                 attr_id, wdata, output rdata, ack, err, online);
   modport master (output restart, cyclic, access, class_id, instance_id,
                   attr_id, wdata, input rdata, ack, err, online);
endinterface : fnp_link_if
`default_nettype wire

/* File: fnp_node.sv */
// Functional notes
// R1: Switches one to six form binary address.
// R2: Switch off reads zero, on reads one.
// R3: Switches seven, eight select 125/250/500 kbit/s.
// R4: Switch changes apply only after restart.
// R5: Power cycle or reset message reloads switches.
// R6: One fixed input, one fixed output image.
// R7: Master picks images via parameters or paths.
// R8: Input image at class 4, instance 1, attribute 3.
// R9: Output image at class 4, instance 21, attribute 3.
// R10: Explicit messages read/write both images too; code refuses input image writes with err.
// R11: Input bits 0-3 carry target signals a-d.
// R12: Combined-state valve types zero bits 0-3.
// R13: Bits 4-7: closed, open, upper, lower lift.
// R14: Raw-signal valve type zeroes bits 4-7.
// R15: Output bits 0-2 drive pilots; 3-7 ignored.
// R16: Zero means off, one means on.
// R17: Bus loss drives pilots to safe state.
// R18: Both rate switches on keeps node off bus.
`timescale 1ns/1ns
`default_nettype none
module fnp_node (
   // Clock and reset
   input wire logic mclk_in,
   input wire logic rst_in,
   // Link to master
   fnp_link_if.node link,
   // Configuration switches and valve setup
   input wire logic [7:0] switch_in,
   input wire fnp_pkg::fnp_vtype_e vtype_in,
   input wire logic [2:0] safe_state_in,
   input wire logic bus_ok_in,
   // Sensor and valve state
   input wire logic [3:0] target_in,
   input wire logic [3:0] valve_state_in,
   // Latched configuration
   output logic [5:0] node_addr_out,
   output fnp_pkg::fnp_rate_e rate_out,
   output logic cfg_valid_out,
   // Pilot drive
   output logic main_stroke_pilot_out,
   output logic upper_seat_pilot_out,
   output logic lower_seat_pilot_out
);
   logic [5:0] addr_ff;
   fnp_pkg::fnp_rate_e rate_ff;
   logic load_ff;
   logic [7:0] out_img_ff;
   logic [7:0] rdata_ff;
   logic ack_ff;
   logic err_ff;
   logic [2:0] pilot_ff;
   logic [7:0] in_img;
   logic is_in;
   logic is_out;

   // Decode rate switches into a rate code
   function automatic fnp_pkg::fnp_rate_e rate_dec(input logic a,
                                                   input logic b);
      case ({b, a})
         2'h0: rate_dec = fnp_pkg::FNP_RATE_125K;
         2'h1: rate_dec = fnp_pkg::FNP_RATE_250K;
         2'h2: rate_dec = fnp_pkg::FNP_RATE_500K;
         default: rate_dec = fnp_pkg::FNP_RATE_BAD;
      endcase
   endfunction : rate_dec

   ////////////////////////////////////////////////////////////////////////
   // Switch capture: one clock after reset release or on restart message
   always_ff @(posedge mclk_in or posedge rst_in) begin
      if (rst_in) begin
         load_ff <= 1'b1;
      end else begin
         load_ff <= link.restart; // R5
      end
   end

   // Latch address and rate only on load
   always_ff @(posedge mclk_in or posedge rst_in) begin
      if (rst_in) begin
         addr_ff <= 6'h00;
         rate_ff <= fnp_pkg::FNP_RATE_BAD;
      end else if (load_ff) begin // R4
         addr_ff <= switch_in[fnp_pkg::ADDR_LSB +: fnp_pkg::ADDR_W]; // R1 R2
         rate_ff <= rate_dec(switch_in[fnp_pkg::RATE_SW_A],
                             switch_in[fnp_pkg::RATE_SW_B]); // R3
      end
   end

   assign node_addr_out = addr_ff;
   assign rate_out = rate_ff;
   assign cfg_valid_out = (rate_ff != fnp_pkg::FNP_RATE_BAD) && !load_ff; // R18
   assign link.online = cfg_valid_out; // R18

   ////////////////////////////////////////////////////////////////////////
   // Input image packing with valve-type masks
   always_comb begin
      in_img = {valve_state_in, target_in}; // R11 R13 R16
      if (vtype_in != fnp_pkg::FNP_VT_RAW) begin
         in_img[fnp_pkg::SENSOR_LSB +: 4] = 4'h0; // R12
      end else begin
         in_img[fnp_pkg::STATE_LSB +: 4] = 4'h0; // R14
      end
   end

   // Object address decode
   always_comb begin
      is_in = 1'b0;
      is_out = 1'b0;
      if (link.class_id == fnp_pkg::IMG_CLASS &&
          link.attr_id == fnp_pkg::IMG_ATTR) begin
         if (link.instance_id == fnp_pkg::IN_INSTANCE) begin
            is_in = 1'b1; // R8 R6
         end else if (link.instance_id == fnp_pkg::OUT_INSTANCE) begin
            is_out = 1'b1; // R9 R6
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Output image store, written by cyclic or explicit write
   always_ff @(posedge mclk_in or posedge rst_in) begin
      if (rst_in) begin
         out_img_ff <= fnp_pkg::OUT_RESET;
      end else if (cfg_valid_out && is_out &&
                   link.access == fnp_pkg::FNP_ACC_WRITE) begin
         out_img_ff <= link.wdata; // R10
      end
   end

   // Read answer, one cycle after request
   always_ff @(posedge mclk_in or posedge rst_in) begin
      if (rst_in) begin
         rdata_ff <= 8'h00;
         ack_ff <= 1'b0;
         err_ff <= 1'b0;
      end else begin
         ack_ff <= cfg_valid_out && link.access != fnp_pkg::FNP_ACC_NONE;
         err_ff <= cfg_valid_out && link.access != fnp_pkg::FNP_ACC_NONE &&
                   !(is_in || is_out) ||
                   (cfg_valid_out && is_in &&
                    link.access == fnp_pkg::FNP_ACC_WRITE);
         if (link.access == fnp_pkg::FNP_ACC_READ && is_in) begin
            rdata_ff <= in_img; // R10
         end else if (link.access == fnp_pkg::FNP_ACC_READ && is_out) begin
            rdata_ff <= out_img_ff; // R10
         end else begin
            rdata_ff <= 8'h00;
         end
      end
   end

   assign link.rdata = rdata_ff;
   assign link.ack = ack_ff;
   assign link.err = err_ff;

   ////////////////////////////////////////////////////////////////////////
   // Pilot drive: image bits 0-2, safe state on bus loss
   always_ff @(posedge mclk_in or posedge rst_in) begin
      if (rst_in) begin
         pilot_ff <= fnp_pkg::SAFE_RESET;
      end else if (!bus_ok_in || !cfg_valid_out) begin
         pilot_ff <= safe_state_in; // R17
      end else begin
         pilot_ff <= out_img_ff[2:0]; // R15 R16
      end
   end

   assign main_stroke_pilot_out = pilot_ff[0];
   assign upper_seat_pilot_out = pilot_ff[1];
   assign lower_seat_pilot_out = pilot_ff[2];
endmodule : fnp_node
`default_nettype wire

/* File: fnp_master.sv */
`timescale 1ns/1ns
`default_nettype none
module fnp_master (
   // Clock and reset
   input wire logic mclk_in,
   input wire logic rst_in,
   // Link to node
   fnp_link_if.master link,
   // Software port
   input wire logic [1:0] addr_in,
   input wire logic [7:0] wdata_in,
   input wire logic wr_in,
   input wire logic rd_in,
   output logic [7:0] rdata_out
);
   localparam logic [1:0] REG_CTRL = 2'h0;
   localparam logic [1:0] REG_OUT = 2'h1;
   localparam logic [1:0] REG_IN = 2'h2;
   localparam logic [1:0] REG_STAT = 2'h3;
   logic [7:0] out_ff;
   logic [7:0] in_ff;
   logic restart_ff;
   logic poll_ff;
   logic err_ff;
   logic [7:0] rdata_ff;

   ////////////////////////////////////////////////////////////////////////
   // Software writes: restart pulse, command image
   always_ff @(posedge mclk_in or posedge rst_in) begin
      if (rst_in) begin
         restart_ff <= 1'b0;
         out_ff <= fnp_pkg::OUT_RESET;
      end else begin
         restart_ff <= wr_in && addr_in == REG_CTRL && wdata_in[0]; // R5
         if (wr_in && addr_in == REG_OUT) begin
            out_ff <= wdata_in;
         end
      end
   end

   // Alternate cyclic write of output image and read of input image
   always_ff @(posedge mclk_in or posedge rst_in) begin
      if (rst_in) begin
         poll_ff <= 1'b0;
         in_ff <= 8'h00;
         err_ff <= 1'b0;
      end else begin
         poll_ff <= !poll_ff;
         if (link.ack && !poll_ff) begin
            in_ff <= link.rdata;
         end
         err_ff <= link.err || (err_ff && !(rd_in && addr_in == REG_STAT));
      end
   end

   assign link.restart = restart_ff;
   assign link.cyclic = link.online;
   assign link.access = !link.online ? fnp_pkg::FNP_ACC_NONE :
                        poll_ff ? fnp_pkg::FNP_ACC_READ :
                        fnp_pkg::FNP_ACC_WRITE;
   assign link.class_id = fnp_pkg::IMG_CLASS; // R7
   assign link.instance_id = poll_ff ? fnp_pkg::IN_INSTANCE :
                             fnp_pkg::OUT_INSTANCE; // R8 R9
   assign link.attr_id = fnp_pkg::IMG_ATTR;
   assign link.wdata = out_ff;

   ////////////////////////////////////////////////////////////////////////
   // Software reads, data one cycle later
   always_ff @(posedge mclk_in or posedge rst_in) begin
      if (rst_in) begin
         rdata_ff <= 8'h00;
      end else if (rd_in) begin
         if (addr_in == REG_OUT) begin
            rdata_ff <= out_ff;
         end else if (addr_in == REG_IN) begin
            rdata_ff <= in_ff;
         end else if (addr_in == REG_STAT) begin
            rdata_ff <= {6'h00, err_ff, link.online};
         end else begin
            rdata_ff <= 8'h00;
         end
      end else begin
         rdata_ff <= 8'h00;
      end
   end

   assign rdata_out = rdata_ff;
endmodule : fnp_master
`default_nettype wire

/* File: fnp_link_sva.sv */
`timescale 1ns/1ns
`default_nettype none
module fnp_link_sva (
   // Clock and reset
   input wire logic mclk_in,
   input wire logic rst_in,
   // Link signals
   input wire logic [1:0] access,
   input wire logic [7:0] class_id,
   input wire logic [7:0] instance_id,
   input wire logic [7:0] attr_id,
   input wire logic [7:0] rdata,
   input wire logic ack,
   input wire logic err,
   input wire logic online
);
   default clocking cb @(posedge mclk_in); endclocking
   default disable iff (rst_in);
   ////////////////////////////////////////////////////////////////////////
   // Class and attribute match
   logic cls_ok;
   assign cls_ok = (class_id == 8'h04) && (attr_id == 8'h03);
   // Requests while offline stay unanswered
   AST_OFFLINE_IGNORED: assert property (
      !online && access != 2'h0 |=> !ack && !err)
      else $error("request answered while offline");
   // Input image read is accepted
   AST_IN_READ: assert property (
      online && access == 2'h1 && cls_ok && instance_id == 8'h01
      |=> ack && !err)
      else $error("input image read not acknowledged");
   // Output image write is accepted
   AST_OUT_WRITE: assert property (
      online && access == 2'h3 && cls_ok && instance_id == 8'h15
      |=> ack && !err)
      else $error("output image write not acknowledged");
   // Output image read on demand
   AST_OUT_READ: assert property (
      online && access == 2'h1 && cls_ok && instance_id == 8'h15
      |=> ack && !err)
      else $error("output image read not acknowledged");
   // Input image is read only
   AST_IN_WRITE_ERR: assert property (
      online && access == 2'h3 && cls_ok && instance_id == 8'h01 |=> err)
      else $error("input image write not refused");
   // Unknown object gives error and zero data
   AST_BAD_ADDR: assert property (
      online && access != 2'h0 && !cls_ok |=> err && rdata == 8'h00)
      else $error("unknown address not refused");
   // Acknowledge only follows a request
   AST_ACK_CAUSE: assert property (
      ack |-> $past(online) && $past(access) != 2'h0)
      else $error("acknowledge without request");
   // Error only follows a request
   AST_ERR_CAUSE: assert property (
      err |-> $past(online) && $past(access) != 2'h0)
      else $error("error without request");
endmodule : fnp_link_sva
`default_nettype wire

/* File: tb_fieldbus_node_process_image.sv */
`timescale 1ns/1ns
`default_nettype none
module tb_fieldbus_node_process_image;
   typedef struct packed {
      logic [7:0] sw;
      logic [1:0] vt;
      logic [3:0] tg;
      logic [3:0] st;
      logic [7:0] cmd;
      logic [7:0] ad;
      logic [7:0] rt;
      logic [7:0] img;
      logic [7:0] pl;
   } fnp_row_s;
   localparam fnp_row_s ROWS [4] = '{
      '{8'h01, 2'h0, 4'hA, 4'h5, 8'hFD, 8'h01, 8'h00, 8'h0A, 8'h05},
      '{8'h7E, 2'h1, 4'hF, 4'h9, 8'h02, 8'h3E, 8'h01, 8'h90, 8'h02},
      '{8'hBF, 2'h2, 4'h3, 4'hC, 8'hF8, 8'h3F, 8'h02, 8'hC0, 8'h00},
      '{8'h20, 2'h3, 4'h1, 4'hF, 8'h07, 8'h20, 8'h00, 8'hF0, 8'h07}};
   logic mclk_in = 1'b0, rst_in = 1'b1, wr_in = 1'b0, rd_in = 1'b0;
   logic bus_ok_in = 1'b1, cfg_valid_out, main_p, upper_p, lower_p;
   logic [1:0] addr_in = 2'h0;
   logic [7:0] wdata_in = 8'h00, switch_in = 8'h05, rdata_out, d;
   logic [2:0] safe_state_in = 3'h0;
   logic [3:0] target_in = 4'h0, valve_state_in = 4'h0;
   logic [5:0] node_addr_out;
   fnp_pkg::fnp_vtype_e vtype_in = fnp_pkg::FNP_VT_RAW;
   fnp_pkg::fnp_rate_e rate_out;
   int n_errors = 0, check_count = 0, cyc = 0;
   // Clock and cycle limit
   always #10 mclk_in = ~mclk_in;
   always @(posedge mclk_in) begin
      cyc++;
      if (cyc == 5000) begin
         n_errors++;
         final_report();
      end
   end
   ////////////////////////////////////////////////////////////////////////
   // Both ends joined by the link
   fnp_link_if fnp_link_if_inst ();
   fnp_master fnp_master_inst (.mclk_in(mclk_in), .rst_in(rst_in),
      .link(fnp_link_if_inst), .addr_in(addr_in), .wdata_in(wdata_in),
      .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out));
   fnp_node fnp_node_inst (.mclk_in(mclk_in), .rst_in(rst_in),
      .link(fnp_link_if_inst), .switch_in(switch_in), .vtype_in(vtype_in),
      .safe_state_in(safe_state_in), .bus_ok_in(bus_ok_in),
      .target_in(target_in), .valve_state_in(valve_state_in),
      .node_addr_out(node_addr_out), .rate_out(rate_out),
      .cfg_valid_out(cfg_valid_out), .main_stroke_pilot_out(main_p),
      .upper_seat_pilot_out(upper_p), .lower_seat_pilot_out(lower_p));
   fnp_link_sva fnp_link_sva_inst (.mclk_in(mclk_in), .rst_in(rst_in),
      .access(fnp_link_if_inst.access), .class_id(fnp_link_if_inst.class_id),
      .instance_id(fnp_link_if_inst.instance_id),
      .attr_id(fnp_link_if_inst.attr_id), .rdata(fnp_link_if_inst.rdata),
      .ack(fnp_link_if_inst.ack), .err(fnp_link_if_inst.err),
      .online(fnp_link_if_inst.online));
   ////////////////////////////////////////////////////////////////////////
   // Software port cycles and compare
   task automatic wr(input logic [1:0] a, input logic [7:0] v);
      @(posedge mclk_in);
      wr_in <= 1'b1;
      addr_in <= a;
      wdata_in <= v;
      @(posedge mclk_in);
      wr_in <= 1'b0;
   endtask : wr
   task automatic rd(input logic [1:0] a);
      @(posedge mclk_in);
      rd_in <= 1'b1;
      addr_in <= a;
      @(posedge mclk_in);
      rd_in <= 1'b0;
      #1 d = rdata_out;
   endtask : rd
   task automatic chk(input string nm, input logic [7:0] e,
                      input logic [7:0] g);
      check_count++;
      if (g !== e) begin
         n_errors++;
         $display("BAD %s exp %h got %h", nm, e, g);
      end
   endtask : chk
   task automatic restart_wait();
      wr(2'h0, 8'h01);
      repeat (6) @(posedge mclk_in);
   endtask : restart_wait
   task automatic final_report();
      $display("checks %0d mismatches %0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : final_report
   ////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      repeat (3) @(posedge mclk_in);
      #1 chk("rst addr", 8'h00, {2'h0, node_addr_out});
      chk("rst pilots", 8'h00, {5'h00, lower_p, upper_p, main_p});
      @(posedge mclk_in);
      rst_in <= 1'b0;
      repeat (4) @(posedge mclk_in);
      chk("boot addr", 8'h05, {2'h0, node_addr_out});
      foreach (ROWS[i]) begin
         switch_in <= ROWS[i].sw;
         vtype_in <= fnp_pkg::fnp_vtype_e'(ROWS[i].vt);
         target_in <= ROWS[i].tg;
         valve_state_in <= ROWS[i].st;
         restart_wait();
         wr(2'h1, ROWS[i].cmd);
         repeat (8) @(posedge mclk_in);
         chk("addr", ROWS[i].ad, {2'h0, node_addr_out});
         chk("rate", ROWS[i].rt, {6'h00, rate_out});
         chk("pilots", ROWS[i].pl, {5'h00, lower_p, upper_p, main_p});
         rd(2'h2);
         chk("in image", ROWS[i].img, d);
         $display("row %0d done", i);
      end
      // Switch change without restart
      switch_in <= 8'h11;
      repeat (10) @(posedge mclk_in);
      chk("held addr", 8'h20, {2'h0, node_addr_out});
      restart_wait();
      chk("new addr", 8'h11, {2'h0, node_addr_out});
      $display("restart test done");
      // Bus loss drives safe state
      safe_state_in <= 3'h5;
      bus_ok_in <= 1'b0;
      repeat (4) @(posedge mclk_in);
      chk("safe", 8'h05, {5'h00, lower_p, upper_p, main_p});
      bus_ok_in <= 1'b1;
      safe_state_in <= 3'h0;
      $display("bus loss test done");
      // Both rate switches on
      switch_in <= 8'hC3;
      restart_wait();
      chk("bad rate", 8'h03, {6'h00, rate_out});
      chk("cfg valid", 8'h00, {7'h00, cfg_valid_out});
      rd(2'h3);
      chk("offline", 8'h00, {7'h00, d[0]});
      switch_in <= 8'h01;
      restart_wait();
      rd(2'h3);
      chk("online", 8'h01, {7'h00, d[0]});
      $display("rate test done");
      final_report();
   end
endmodule : tb_fieldbus_node_process_image
`default_nettype wire
